// [rtl/txsa_top.v]
`timescale 1ns/1ns
`default_nettype none
`include "txsa_defines.vh"
// ****************************************
// Transmit address insert and statistics control
// ****************************************
module txsa_top
#(
  parameter CLR_CYCLES = `TXSA_CLR_CYCLES
)
(
  input  wire        pclk,
  input  wire        presetn,
  input  wire        ce,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [15:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        tx_in_valid,
  output wire        tx_in_ready,
  input  wire [63:0] tx_in_data,
  input  wire        tx_in_sop,
  input  wire        tx_in_eop,
  input  wire [2:0]  tx_in_empty,
  output wire        tx_out_valid,
  input  wire        tx_out_ready,
  output wire [63:0] tx_out_data,
  output wire        tx_out_sop,
  output wire        tx_out_eop,
  output wire [2:0]  tx_out_empty,
  output wire        tx_status_valid,
  output wire [`TXSA_ST_W-1:0] tx_status_error_flags,
  output reg         rx_stats_clear,
  output reg         tx_stats_clear,
  output reg         irq
);
  // ****************************************
  // Helpers
  // ****************************************
  function is_mapped;
    input [13:0] idx;
    begin
      is_mapped = (idx == `TXSA_IDX_RXCLR)  ||
                  (idx == `TXSA_IDX_CTRL)   ||
                  (idx == `TXSA_IDX_ADDRLO) ||
                  (idx == `TXSA_IDX_ADDRHI) ||
                  (idx == `TXSA_IDX_IRQST)  ||
                  (idx == `TXSA_IDX_IRQMSK) ||
                  (idx == `TXSA_IDX_MAXLEN) ||
                  (idx == `TXSA_IDX_TXCLR);
    end
  endfunction

  // Only bit 0 starts a clear; reserved bits are ignored
  function clr_hit;
    input [13:0] at;
    input [13:0] target;
    input [31:0] data;
    begin
      clr_hit = (at == target) && data[`TXSA_CLR_BIT];
    end
  endfunction

  function [`TXSA_IRQ_W-1:0] w1c;
    input [`TXSA_IRQ_W-1:0] cur;
    input [`TXSA_IRQ_W-1:0] ones;
    begin
      w1c = cur & ~ones;
    end
  endfunction

  localparam CW = 8;
  localparam [CW-1:0] CLR_LAST = CLR_CYCLES[CW-1:0] - 1'b1;

  // ****************************************
  // Registers
  // ****************************************
  reg                    ins_en_r;
  reg  [31:0]            addr_lo_r;
  reg  [`TXSA_HI_W-1:0]  addr_hi_r;
  reg  [`TXSA_LEN_W-1:0] max_len_r;
  reg  [`TXSA_IRQ_W-1:0] irq_st_r;
  reg  [`TXSA_IRQ_W-1:0] irq_msk_r;
  reg  [`TXSA_IRQ_W-1:0] irq_st_nxt;
  reg  [CW-1:0]          rx_cnt_r;
  reg  [CW-1:0]          tx_cnt_r;
  reg  [31:0]            rd_nxt;

  wire [13:0] idx;
  wire        aligned;
  wire        hit;
  wire        acc;
  wire        wr;
  wire        rx_done;
  wire        tx_done;
  wire [47:0] station;
  wire        in_take;
  wire        wr_rxclr;
  wire        wr_txclr;
  wire        wr_irqst;

  assign idx     = paddr[15:2];
  assign aligned = (paddr[1:0] == 2'h0);
  assign hit     = aligned && is_mapped(idx);
  assign acc     = psel && penable && pready;
  assign wr      = acc && pwrite && hit;
  // Octet 1 is the top of the 48-bit station address
  assign station = {addr_hi_r, addr_lo_r};
  assign rx_done = rx_stats_clear && (rx_cnt_r == CLR_LAST);
  assign tx_done = tx_stats_clear && (tx_cnt_r == CLR_LAST);
  assign in_take = tx_in_valid && tx_in_ready;

  // ****************************************
  // Write strobes
  // ****************************************
  // A clear write only starts a sequence when bit 0 is one
  assign wr_rxclr = wr && clr_hit(idx, `TXSA_IDX_RXCLR, pwdata);
  assign wr_txclr = wr && clr_hit(idx, `TXSA_IDX_TXCLR, pwdata);
  assign wr_irqst = wr && (idx == `TXSA_IDX_IRQST);

  // ****************************************
  // Read mux
  // ****************************************
  always @*
  begin
    rd_nxt = 32'h0000_0000;
    case (idx)
      `TXSA_IDX_RXCLR:
        rd_nxt[`TXSA_CLR_BIT] = rx_stats_clear;
      `TXSA_IDX_TXCLR:
        rd_nxt[`TXSA_CLR_BIT] = tx_stats_clear;
      `TXSA_IDX_CTRL:
        rd_nxt[`TXSA_EN_BIT] = ins_en_r;
      `TXSA_IDX_ADDRLO:
        rd_nxt = addr_lo_r;
      `TXSA_IDX_ADDRHI:
        rd_nxt[`TXSA_HI_W-1:0] = addr_hi_r;
      `TXSA_IDX_MAXLEN:
        rd_nxt[`TXSA_LEN_W-1:0] = max_len_r;
      `TXSA_IDX_IRQST:
        rd_nxt[`TXSA_IRQ_W-1:0] = irq_st_r;
      `TXSA_IDX_IRQMSK:
        rd_nxt[`TXSA_IRQ_W-1:0] = irq_msk_r;
      default:
        rd_nxt = 32'h0000_0000;
    endcase
    if (!aligned)
      rd_nxt = 32'h0000_0000;
  end

  // ****************************************
  // APB slave
  // ****************************************
  // No wait states: data and error are flopped in setup
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
    else if (ce)
    begin
      pready  <= psel && !penable && !pready;
      pslverr <= psel && !penable && !hit;
      if (psel && !penable)
        prdata <= pwrite ? 32'h0000_0000 : rd_nxt;
    end
  end

  // ****************************************
  // Configuration registers
  // ****************************************
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ins_en_r  <= 1'b0;
      addr_lo_r <= 32'h0000_0000;
      addr_hi_r <= 16'h0000;
      max_len_r <= `TXSA_MAXLEN_RST;
      irq_msk_r <= {`TXSA_IRQ_W{1'b0}};
    end
    else if (ce && wr)
    begin
      case (idx)
        `TXSA_IDX_CTRL:
          ins_en_r <= pwdata[`TXSA_EN_BIT];
        `TXSA_IDX_ADDRLO:
          addr_lo_r <= pwdata;
        `TXSA_IDX_ADDRHI:
          addr_hi_r <= pwdata[`TXSA_HI_W-1:0];
        `TXSA_IDX_MAXLEN:
          max_len_r <= pwdata[`TXSA_LEN_W-1:0];
        `TXSA_IDX_IRQMSK:
          irq_msk_r <= pwdata[`TXSA_IRQ_W-1:0];
        default:
          irq_msk_r <= irq_msk_r;
      endcase
    end
  end

  // ****************************************
  // Statistics clear sequencers
  // ****************************************
  // Clear is held for CLR_CYCLES so slow counter banks all see it;
  // a new write while busy restarts nothing and is simply absorbed.
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_stats_clear <= 1'b0;
      rx_cnt_r       <= {CW{1'b0}};
    end
    else if (ce)
    begin
      if (rx_stats_clear)
      begin
        rx_cnt_r <= rx_cnt_r + {{(CW-1){1'b0}}, 1'b1};
        if (rx_done)
        begin
          rx_stats_clear <= 1'b0;
          rx_cnt_r       <= {CW{1'b0}};
        end
      end
      else if (wr_rxclr)
        rx_stats_clear <= 1'b1;
    end
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_stats_clear <= 1'b0;
      tx_cnt_r       <= {CW{1'b0}};
    end
    else if (ce)
    begin
      if (tx_stats_clear)
      begin
        tx_cnt_r <= tx_cnt_r + {{(CW-1){1'b0}}, 1'b1};
        if (tx_done)
        begin
          tx_stats_clear <= 1'b0;
          tx_cnt_r       <= {CW{1'b0}};
        end
      end
      else if (wr_txclr)
        tx_stats_clear <= 1'b1;
    end
  end

  // ****************************************
  // Interrupts
  // ****************************************
  // Set wins over a write-one clear in the same cycle
  always @*
  begin
    irq_st_nxt = irq_st_r;
    if (wr_irqst)
      irq_st_nxt = w1c(irq_st_r, pwdata[`TXSA_IRQ_W-1:0]);
    if (tx_status_valid && tx_status_error_flags[`TXSA_ST_OVS])
      irq_st_nxt[`TXSA_IRQ_OVS] = 1'b1;
    if (rx_done)
      irq_st_nxt[`TXSA_IRQ_RXCLR] = 1'b1;
    if (tx_done)
      irq_st_nxt[`TXSA_IRQ_TXCLR] = 1'b1;
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_st_r <= {`TXSA_IRQ_W{1'b0}};
      irq      <= 1'b0;
    end
    else if (ce)
    begin
      irq_st_r <= irq_st_nxt;
      irq      <= |(irq_st_nxt & irq_msk_r);
    end
  end

  // ****************************************
  // Datapath
  // ****************************************
  // Length is judged on the input side; the check itself never holds a beat back
  txsa_len_chk u_len
  (
    .pclk     (pclk),
    .presetn  (presetn),
    .ce       (ce),
    .max_len  (max_len_r),
    .beat     (in_take),
    .sop      (tx_in_sop),
    .eop      (tx_in_eop),
    .empty    (tx_in_empty),
    .st_valid (tx_status_valid),
    .st_error (tx_status_error_flags)
  );

  txsa_sa_insert u_ins
  (
    .pclk         (pclk),
    .presetn      (presetn),
    .ce           (ce),
    .enable       (ins_en_r),
    .station_addr (station),
    .in_valid     (tx_in_valid),
    .in_ready     (tx_in_ready),
    .in_data      (tx_in_data),
    .in_sop       (tx_in_sop),
    .in_eop       (tx_in_eop),
    .in_empty     (tx_in_empty),
    .out_valid    (tx_out_valid),
    .out_ready    (tx_out_ready),
    .out_data     (tx_out_data),
    .out_sop      (tx_out_sop),
    .out_eop      (tx_out_eop),
    .out_empty    (tx_out_empty)
  );
endmodule
`default_nettype wire

// [rtl/txsa_defines.vh]
`ifndef TXSA_DEFINES_VH
`define TXSA_DEFINES_VH
// ****************************************
// Register word indexes (byte address = 4 x index)
// ****************************************
`define TXSA_IDX_RXCLR   14'h0C00
`define TXSA_IDX_CTRL    14'h1200
`define TXSA_IDX_ADDRLO  14'h1201
`define TXSA_IDX_ADDRHI  14'h1202
`define TXSA_IDX_IRQST   14'h1204
`define TXSA_IDX_IRQMSK  14'h1205
`define TXSA_IDX_MAXLEN  14'h1801
`define TXSA_IDX_TXCLR   14'h1C00
// ****************************************
// Field positions and reset values
// ****************************************
`define TXSA_EN_BIT      0
`define TXSA_CLR_BIT     0
`define TXSA_HI_W        16
`define TXSA_LEN_W       16
`define TXSA_MAXLEN_RST  16'h05EE
`define TXSA_ST_OVS      1
`define TXSA_ST_W        2
`define TXSA_IRQ_OVS     0
`define TXSA_IRQ_RXCLR   1
`define TXSA_IRQ_TXCLR   2
`define TXSA_IRQ_W       3
`define TXSA_CLR_CYCLES  16
`define TXSA_BEAT_BYTES  17'h0_0008
`endif

// [rtl/txsa_sa_insert.v]
`timescale 1ns/1ns
`default_nettype none
// ****************************************
// Source address overwrite, one register stage
// ****************************************
module txsa_sa_insert
(
  input  wire        pclk,
  input  wire        presetn,
  input  wire        ce,
  input  wire        enable,
  input  wire [47:0] station_addr,
  input  wire        in_valid,
  output wire        in_ready,
  input  wire [63:0] in_data,
  input  wire        in_sop,
  input  wire        in_eop,
  input  wire [2:0]  in_empty,
  output reg         out_valid,
  input  wire        out_ready,
  output reg  [63:0] out_data,
  output reg         out_sop,
  output reg         out_eop,
  output reg  [2:0]  out_empty
);
  reg  [1:0]  idx_r;
  reg         en_frame_r;
  wire [1:0]  cur;
  wire        en_now;
  wire        take;
  reg  [63:0] data_nxt;

  assign in_ready = !out_valid || out_ready;
  assign take     = in_valid && in_ready;
  assign cur      = in_sop ? 2'h0 : idx_r;
  // Enable is frozen per frame so a frame is never half rewritten
  assign en_now   = (cur == 2'h0) ? enable : en_frame_r;

  // Byte 0 of a beat sits in bits 63:56; source address is bytes 6..11
  always @*
  begin
    data_nxt = in_data;
    if (en_now && cur == 2'h0)
      data_nxt[15:0] = station_addr[47:32];
    else if (en_now && cur == 2'h1)
      data_nxt[63:32] = station_addr[31:0];
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      idx_r      <= 2'h0;
      en_frame_r <= 1'b0;
      out_valid  <= 1'b0;
      out_data   <= 64'h0000_0000_0000_0000;
      out_sop    <= 1'b0;
      out_eop    <= 1'b0;
      out_empty  <= 3'h0;
    end
    else if (ce)
    begin
      if (in_ready)
        out_valid <= in_valid;
      if (take)
      begin
        out_data   <= data_nxt;
        out_sop    <= in_sop;
        out_eop    <= in_eop;
        out_empty  <= in_empty;
        en_frame_r <= en_now;
        if (in_eop)
          idx_r <= 2'h0;
        else if (cur != 2'h2)
          idx_r <= cur + 2'h1;
        else
          idx_r <= cur;
      end
    end
  end
endmodule
`default_nettype wire

// [rtl/txsa_len_chk.v]
`timescale 1ns/1ns
`default_nettype none
`include "txsa_defines.vh"
// ****************************************
// Frame length measure against the limit
// ****************************************
module txsa_len_chk
(
  input  wire        pclk,
  input  wire        presetn,
  input  wire        ce,
  input  wire [15:0] max_len,
  input  wire        beat,
  input  wire        sop,
  input  wire        eop,
  input  wire [2:0]  empty,
  output reg         st_valid,
  output reg  [`TXSA_ST_W-1:0] st_error
);
  reg  [16:0] len_r;
  wire [16:0] base;
  wire [16:0] sum;
  wire [16:0] total;

  assign base  = sop ? 17'h0_0000 : len_r;
  assign sum   = base + `TXSA_BEAT_BYTES;
  // Saturate so a very long frame still reads as oversized
  assign total = len_r[16] ? len_r : (sum - {14'h0000, empty});

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      len_r    <= 17'h0_0000;
      st_valid <= 1'b0;
      st_error <= {`TXSA_ST_W{1'b0}};
    end
    else if (ce)
    begin
      st_valid <= beat && eop;
      st_error <= {`TXSA_ST_W{1'b0}};
      if (beat)
      begin
        len_r <= eop ? 17'h0_0000 : total;
        if (eop && total > {1'b0, max_len})
          st_error[`TXSA_ST_OVS] <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// [testbench/txsa_top_properties.sv]
`timescale 1ns/1ns
`default_nettype none
// ************
// Port checks
// ************
module txsa_checker
#(
  parameter int CLR_CYCLES = 16
)
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        ce,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        tx_in_valid,
  input wire logic        tx_in_ready,
  input wire logic        tx_in_eop,
  input wire logic [2:0]  tx_in_empty,
  input wire logic        tx_out_valid,
  input wire logic        tx_status_valid,
  input wire logic [1:0]  tx_status_error_flags,
  input wire logic        rx_stats_clear,
  input wire logic        tx_stats_clear
);
  logic        acc, wr, ovs;
  logic [16:0] cnt_r, len;
  logic [15:0] lim_r;
  logic [7:0]  rc_r, tc_r;
  assign acc = tx_in_valid && tx_in_ready && ce;
  assign wr  = psel && penable && pready && pwrite && !pslverr && ce;
  assign len = cnt_r + 17'h0_0008 - {14'h0000, tx_in_empty};
  assign ovs = len > {1'b0, lim_r};
  // Mirror of the limit, so the flag is judged without peeking inside
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_r <= 17'h0_0000;
      lim_r <= 16'h05EE;
      rc_r  <= 8'h00;
      tc_r  <= 8'h00;
    end
    else
    begin
      cnt_r <= !acc ? cnt_r : tx_in_eop ? 17'h0_0000 : len;
      lim_r <= (wr && paddr == 16'h6004) ? pwdata[15:0] : lim_r;
      rc_r  <= rx_stats_clear ? rc_r + {7'h00, ce} : 8'h00;
      tc_r  <= tx_stats_clear ? tc_r + {7'h00, ce} : 8'h00;
    end
  end
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence s_setup; psel && !penable && ce; endsequence
  sequence s_eop; acc && tx_in_eop; endsequence
  property p_apb_ready; s_setup |=> pready; endproperty
  a_apb_ready: assert property (p_apb_ready)
    else $error("pready missing");
  property p_limit_read; psel && penable && pready && !pwrite
    && paddr == 16'h6004 |-> prdata == {16'h0000, lim_r}; endproperty
  a_limit_read: assert property (p_limit_read)
    else $error("limit readback");
  property p_pass; acc |=> tx_out_valid; endproperty
  a_pass: assert property (p_pass)
    else $error("beat dropped");
  property p_status; s_eop |=> tx_status_valid
    && tx_status_error_flags == {$past(ovs), 1'b0}; endproperty
  a_status: assert property (p_status)
    else $error("status flags");
  property p_rx_start; wr && paddr == 16'h3000 && pwdata[0]
    && !rx_stats_clear |=> rx_stats_clear; endproperty
  a_rx_start: assert property (p_rx_start)
    else $error("rx clear not started");
  property p_rx_len; (!rx_stats_clear || rc_r < CLR_CYCLES) &&
    (rx_stats_clear || rc_r == 0 || rc_r == CLR_CYCLES); endproperty
  a_rx_len: assert property (p_rx_len)
    else $error("rx clear length");
  property p_tx_start; wr && paddr == 16'h7000 && pwdata[0]
    && !tx_stats_clear |=> tx_stats_clear; endproperty
  a_tx_start: assert property (p_tx_start)
    else $error("tx clear not started");
  property p_tx_len; (!tx_stats_clear || tc_r < CLR_CYCLES) &&
    (tx_stats_clear || tc_r == 0 || tc_r == CLR_CYCLES); endproperty
  a_tx_len: assert property (p_tx_len)
    else $error("tx clear length");
  property p_freeze; !ce |=> $stable(rx_stats_clear) &&
    $stable(tx_stats_clear) && $stable(pready) && $stable(tx_out_valid);
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("state moved with clock enable low");
endmodule
bind txsa_top txsa_checker #(.CLR_CYCLES(CLR_CYCLES)) u_chk (
  .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .tx_in_valid(tx_in_valid),
  .tx_in_ready(tx_in_ready), .tx_in_eop(tx_in_eop),
  .tx_in_empty(tx_in_empty), .tx_out_valid(tx_out_valid),
  .tx_status_valid(tx_status_valid),
  .tx_status_error_flags(tx_status_error_flags),
  .rx_stats_clear(rx_stats_clear), .tx_stats_clear(tx_stats_clear));
`default_nettype wire

// [testbench/txsa_sink_model.sv]
`timescale 1ns/1ns
`default_nettype none
// ************
// Frame sink, prompt or stalling
// ************
module txsa_sink_model
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        stall,
  input  wire logic        valid,
  input  wire logic [63:0] data,
  input  wire logic        sop,
  input  wire logic        eop,
  input  wire logic [2:0]  empty,
  output var  logic        ready
);
  logic [1:0]  ph_r;
  logic [68:0] got[$];
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ph_r  <= 2'h0;
      ready <= 1'b0;
    end
    else
    begin
      ph_r  <= ph_r + 2'h1;
      ready <= !stall || ph_r == 2'h3;
      if (valid && ready)
        got.push_back({sop, eop, empty, data});
    end
  end
endmodule
`default_nettype wire

// [testbench/txsa_top_tb_top.sv]
`timescale 1ns/1ns
`default_nettype none
module txsa_top_tb_top;
  localparam int CLR = 4;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic        tx_in_valid, tx_in_ready, tx_in_sop, tx_in_eop, stall, en;
  logic        tx_out_valid, tx_out_ready, tx_out_sop, tx_out_eop, er;
  logic        tx_status_valid, rx_stats_clear, tx_stats_clear, ce;
  logic [15:0] paddr, ca;
  logic [31:0] pwdata, prdata, rd;
  logic [63:0] tx_in_data, tx_out_data;
  logic [2:0]  tx_in_empty, tx_out_empty;
  logic [1:0]  tx_status_error_flags, st_f;
  logic [47:0] sa;
  logic [68:0] exp_q[$];
  int          fail_count, checks_done, seed, cyc, st_n, r;
  txsa_top #(.CLR_CYCLES(CLR)) u_txsa_top (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .tx_in_valid(tx_in_valid), .tx_in_ready(tx_in_ready),
    .tx_in_data(tx_in_data), .tx_in_sop(tx_in_sop), .tx_in_eop(tx_in_eop),
    .tx_in_empty(tx_in_empty), .tx_out_valid(tx_out_valid),
    .tx_out_ready(tx_out_ready), .tx_out_data(tx_out_data),
    .tx_out_sop(tx_out_sop), .tx_out_eop(tx_out_eop),
    .tx_out_empty(tx_out_empty), .tx_status_valid(tx_status_valid),
    .tx_status_error_flags(tx_status_error_flags),
    .rx_stats_clear(rx_stats_clear), .tx_stats_clear(tx_stats_clear),
    .irq(irq));
  txsa_sink_model u_txsa_sink_model (
    .pclk(pclk), .presetn(presetn), .stall(stall), .valid(tx_out_valid),
    .data(tx_out_data), .sop(tx_out_sop), .eop(tx_out_eop),
    .empty(tx_out_empty), .ready(tx_out_ready));
  initial
  begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  task chk(input logic [68:0] g, input logic [68:0] e);
    checks_done++;
    if (g !== e)
    begin
      fail_count++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task rchk(input logic [15:0] a, input logic [32:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk({er, rd}, e);
  endtask
  // Limit set just around the length, so both sides of it are hit
  task frame(input int n, input int e, input int dl);
    logic [63:0] d;
    int          s0;
    apb(1'b1, 16'h6004, 8 * n - e + dl);
    s0 = st_n;
    for (int i = 0; i < n; i++)
    begin
      d = {$random(seed), $random(seed)};
      tx_in_valid <= 1'b1;
      tx_in_data  <= d;
      tx_in_sop   <= i == 0;
      tx_in_eop   <= i == n - 1;
      tx_in_empty <= i == n - 1 ? e[2:0] : 3'h0;
      if (en && i == 0) d[15:0] = sa[47:32];
      if (en && i == 1) d[63:32] = sa[31:0];
      exp_q.push_back({i == 0, i == n - 1, i == n - 1 ? e[2:0] : 3'h0, d});
      do @(posedge pclk); while (tx_in_ready !== 1'b1);
    end
    tx_in_valid <= 1'b0;
    while (u_txsa_sink_model.got.size() < exp_q.size()) @(posedge pclk);
    repeat (2) @(posedge pclk);
    foreach (exp_q[i]) chk(u_txsa_sink_model.got[i], exp_q[i]);
    chk(st_n - s0, 1);
    chk(st_f, {dl < 0, 1'b0});
    exp_q.delete();
    u_txsa_sink_model.got.delete();
  endtask
  task print_verdict;
    if (fail_count == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (tx_status_valid === 1'b1)
      st_n <= st_n + 1;
    if (tx_status_valid === 1'b1)
      st_f <= tx_status_error_flags;
    if (cyc == 20000)
    begin
      fail_count++;
      print_verdict;
    end
  end
  initial
  begin
    seed = 61516;
    ce = 1'b1;
    {psel, penable, pwrite, tx_in_valid, tx_in_sop, tx_in_eop, stall} = 7'h00;
    {paddr, pwdata, tx_in_data, tx_in_empty, en} = 116'h0;
    presetn = 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rchk(16'h3000, 33'h0);
    rchk(16'h4800, 33'h0);
    rchk(16'h4804, 33'h0);
    rchk(16'h4808, 33'h0);
    rchk(16'h6004, 33'h0_0000_05EE);
    rchk(16'h7000, 33'h0);
    rchk(16'h480C, 33'h1_0000_0000);
    rchk(16'h6006, 33'h1_0000_0000);
    rd = $random(seed);
    sa = {rd[15:0], $random(seed)};
    apb(1'b1, 16'h4804, sa[31:0]);
    apb(1'b1, 16'h4808, {rd[31:16], sa[47:32]});
    apb(1'b1, 16'h4800, 32'hFFFF_FFFF);
    rchk(16'h4804, {1'b0, sa[31:0]});
    rchk(16'h4808, {17'h0_0000, sa[47:32]});
    rchk(16'h4800, 33'h0_0000_0001);
    en = 1'b1;
    frame(1, 7, 0);
    frame(3, 0, -1);
    for (int k = 0; k < 12; k++)
    begin
      en = k < 6;
      apb(1'b1, 16'h4800, {31'h0000_0000, en});
      stall <= k[0];
      r = $random(seed);
      frame(1 + r[1:0], r[4:2], int'(r[6:5] % 3) - 1);
    end
    frame(2, 0, -1);
    rchk(16'h4810, 33'h0_0000_0001);
    chk(irq, 1'b0);
    apb(1'b1, 16'h4814, 32'h0000_0001);
    rchk(16'h4814, 33'h0_0000_0001);
    repeat (2) @(posedge pclk);
    chk(irq, 1'b1);
    apb(1'b1, 16'h4810, 32'h0000_0001);
    repeat (2) @(posedge pclk);
    chk(irq, 1'b0);
    for (int j = 0; j < 2; j++)
    begin
      ca = j ? 16'h7000 : 16'h3000;
      apb(1'b1, ca, 32'h0000_0001);
      rchk(ca, 33'h0_0000_0001);
      chk(j ? tx_stats_clear : rx_stats_clear, 1'b1);
      // Clock enable low must hold the clear mid-sequence
      ce <= 1'b0;
      repeat (CLR + 2) @(posedge pclk);
      chk(j ? tx_stats_clear : rx_stats_clear, 1'b1);
      ce <= 1'b1;
      repeat (CLR + 2) @(posedge pclk);
      rchk(ca, 33'h0);
      chk({tx_stats_clear, rx_stats_clear}, 2'b00);
    end
    rchk(16'h4810, 33'h0_0000_0006);
    print_verdict;
  end
endmodule
`default_nettype wire
